// [logic/aac_cfg.svh]
`ifndef AAC_CFG_SVH
`define AAC_CFG_SVH

// Register offsets, byte-wide registers on an 8-bit address
`define AAC_ADDR_DIAG2 8'hE0
`define AAC_ADDR_MODE 8'hE1
`define AAC_ADDR_EN1 8'hE2
`define AAC_ADDR_EN2 8'hE3
`define AAC_ADDR_EN3 8'hE4
`define AAC_ADDR_CTRL 8'hE5
`define AAC_ADDR_STAT 8'hE6
`define AAC_ADDR_PTAT 8'hE7
// Result groups occupy 8 bytes per channel below this address
`define AAC_RES_END 8'hA8

// Byte positions inside a result group
`define AAC_B_CORR_H 3'h0
`define AAC_B_CORR_L 3'h1
`define AAC_B_UNC_H 3'h2
`define AAC_B_UNC_M 3'h3
`define AAC_B_UNC_L 3'h4

// Field positions
`define AAC_DIAG2_SEL_MSB 2
`define AAC_DIAG2_SELEN_BIT 3
`define AAC_EN1_STACK_BIT 6
`define AAC_CTRL_GO_BIT 0
`define AAC_CTRL_TREF_BIT 1
`define AAC_CTRL_PTAT_BIT 2

// Round-robin channel indices and count
`define AAC_CH_CELL 5'd0
`define AAC_CH_BAT 5'd1
`define AAC_CH_GPIO1 5'd5
`define AAC_CH_GPIO6 5'd10
`define AAC_NUM_CH 5'd21

// Diagnostic code of a result that is not ready yet
`define AAC_DIAG_WORD 24'h80_0000

`endif

// [logic/aac_pkg.sv]
`include "aac_cfg.svh"

package aac_pkg;
   typedef enum logic [1:0] {AAC_IDLE, AAC_SCAN, AAC_WAIT} aac_state_t;

   // Picks one byte of a result group from a 24-bit conversion word
   function automatic logic [7:0] aac_sel_byte(input logic [23:0] word, input logic [4:0] ch,
                                               input logic [2:0] bsel);
      logic hasUnc;
      logic is24;
      hasUnc = (ch == `AAC_CH_BAT) || ((ch >= `AAC_CH_GPIO1) && (ch <= `AAC_CH_GPIO6));
      is24 = (ch == `AAC_CH_BAT) || (ch == `AAC_CH_GPIO1);
      unique case (bsel)
         `AAC_B_CORR_H: aac_sel_byte = word[23:16];
         `AAC_B_CORR_L: aac_sel_byte = word[15:8];
         `AAC_B_UNC_H: aac_sel_byte = hasUnc ? word[23:16] : 8'h00;
         `AAC_B_UNC_M: aac_sel_byte = is24 ? word[15:8] : 8'h00;
         `AAC_B_UNC_L: aac_sel_byte = is24 ? word[7:0] : (hasUnc ? word[15:8] : 8'h00);
         default: aac_sel_byte = 8'h00;
      endcase
   endfunction
endpackage

// [logic/aac_result_mem.sv]
`include "aac_cfg.svh"

module aac_result_mem
   import aac_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic wrEn,
   input wire logic [4:0] wrChan,
   input wire logic [23:0] wrData,
   input wire logic rdEn,
   input wire logic [4:0] rdChan,
   input wire logic [2:0] rdByte,
   input wire logic bypassEn,
   input wire logic [7:0] bypassByte,
   output logic [7:0] rdData_r,
   output logic [23:0] rdWord_r
);
   logic [23:0] store [0:20];
   logic [20:0] valid_r;
   logic [20:0] valid_nxt;
   logic [7:0] rdData_nxt;
   logic [23:0] rdWord_nxt;
   logic [23:0] liveWord;

   // Result words carry no reset; the valid bits hide them until first written
   always_ff @(posedge clk)
   begin
      if (wrEn)
         store[wrChan] <= wrData;
   end

   // Per-entry valid bits
   generate
      for (genvar i = 0; i < 21; i++)
      begin : g_valid
         assign valid_nxt[i] = valid_r[i] | (wrEn && (wrChan == 5'(i)));
      end
   endgenerate

   // Read port: a channel never converted answers with the diagnostic code
   always_comb
   begin
      liveWord = (rdEn && valid_r[rdChan]) ? store[rdChan] : `AAC_DIAG_WORD;
      rdWord_nxt = rdEn ? liveWord : rdWord_r;
      rdData_nxt = rdData_r;
      if (bypassEn)
         rdData_nxt = bypassByte;
      else if (rdEn)
         rdData_nxt = aac_sel_byte(liveWord, rdChan, rdByte);
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         valid_r <= 21'h0;
         rdData_r <= 8'h00;
         rdWord_r <= 24'h00_0000;
      end
      else
      begin
         valid_r <= valid_nxt;
         rdData_r <= rdData_nxt;
         rdWord_r <= rdWord_nxt;
      end
   end
endmodule

// [logic/aac_sequencer.sv]
`include "aac_cfg.svh"

module aac_sequencer
   import aac_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic go,
   input wire logic [20:0] enMask,
   input wire logic [5:0] gpioMode,
   input wire logic convDone,
   input wire logic [23:0] convData,
   output logic convStart_r,
   output logic [4:0] convChan_r,
   output logic convAbort_r,
   output logic convRatio_r,
   output logic wrEn_r,
   output logic [4:0] wrChan_r,
   output logic [23:0] wrData_r,
   output logic running_r,
   output logic finish_r
);
   aac_state_t state_r, state_nxt;
   logic [4:0] chan_nxt;
   logic start_nxt, abort_nxt, ratio_nxt, wrEn_nxt, run_nxt, fin_nxt;
   logic [4:0] wrChan_nxt;
   logic [23:0] wrData_nxt;
   logic isGpio;

   // Walk the channels in fixed order, skipping disabled ones
   always_comb
   begin
      state_nxt = state_r;
      chan_nxt = convChan_r;
      start_nxt = 1'b0;
      abort_nxt = 1'b0;
      ratio_nxt = convRatio_r;
      wrEn_nxt = 1'b0;
      wrChan_nxt = wrChan_r;
      wrData_nxt = wrData_r;
      run_nxt = running_r;
      fin_nxt = 1'b0;
      isGpio = (convChan_r >= `AAC_CH_GPIO1) && (convChan_r <= `AAC_CH_GPIO6);
      if (go)
      begin
         abort_nxt = running_r;
         state_nxt = AAC_SCAN;
         chan_nxt = `AAC_CH_CELL;
         run_nxt = 1'b1;
      end
      else
         unique case (state_r)
            AAC_IDLE: ;
            AAC_SCAN:
               if (convChan_r == `AAC_NUM_CH)
               begin
                  state_nxt = AAC_IDLE;
                  run_nxt = 1'b0;
                  fin_nxt = 1'b1;
               end
               else if (enMask[convChan_r])
               begin
                  start_nxt = 1'b1;
                  ratio_nxt = isGpio ? gpioMode[3'(convChan_r - `AAC_CH_GPIO1)] : 1'b0;
                  state_nxt = AAC_WAIT;
               end
               else
                  chan_nxt = convChan_r + 5'd1;
            AAC_WAIT:
               if (convDone)
               begin
                  wrEn_nxt = 1'b1;
                  wrChan_nxt = convChan_r;
                  wrData_nxt = convData;
                  chan_nxt = convChan_r + 5'd1;
                  state_nxt = AAC_SCAN;
               end
         endcase
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         state_r <= AAC_IDLE;
         convChan_r <= 5'd0;
         convStart_r <= 1'b0;
         convAbort_r <= 1'b0;
         convRatio_r <= 1'b0;
         wrEn_r <= 1'b0;
         wrChan_r <= 5'd0;
         wrData_r <= 24'h00_0000;
         running_r <= 1'b0;
         finish_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         convChan_r <= chan_nxt;
         convStart_r <= start_nxt;
         convAbort_r <= abort_nxt;
         convRatio_r <= ratio_nxt;
         wrEn_r <= wrEn_nxt;
         wrChan_r <= wrChan_nxt;
         wrData_r <= wrData_nxt;
         running_r <= run_nxt;
         finish_r <= fin_nxt;
      end
   end

   a_only_enabled: assert property (@(posedge clk) disable iff (reset)
      convStart_r |-> $past(enMask[convChan_r]))
      else $error("conversion started on a disabled channel");
   a_done_writes: assert property (@(posedge clk) disable iff (reset)
      (state_r == AAC_WAIT && convDone && !go) |=> wrEn_r && wrChan_r == $past(convChan_r))
      else $error("finished conversion was not written to its group");
   a_run_ends: assert property (@(posedge clk) disable iff (reset)
      finish_r |-> !running_r && !wrEn_r)
      else $error("round finished while still running or writing");
endmodule

// [logic/aac_result_readout.sv]
// The strobed register port and the placing of the registers are this design's own decisions.
`include "aac_cfg.svh"

// How it works
// - Reference and rail codes pass unscaled, two's complement
// - Comm supply rail code passes unscaled too
// - Selected, enabled cell routed and converted
// - Any cell selected suspends window comparator
// - Cell result low byte frozen after high read
// - Per-input mode bits and enable bits
// - Ratiometric input codes pass as two's complement
// - Absolute input codes pass as two's complement
// - Input results sixteen bits, first uncorrected 24
// - High byte read freezes lower bytes snapshot
// - Stack voltage converted only when enabled
// - Stack result 16 corrected, 24 uncorrected
// - No range checking of rail results
// - Window DAC channels report half reference
// - Factory PTAT offset readable, 1 mV steps
// - Running flag, then ready after all writes
// - Early result read returns diagnostic code
// - Trigger during run aborts and restarts round
module aac_result_readout
   import aac_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdData,
   input wire logic convDone,
   input wire logic [23:0] convData,
   input wire logic [7:0] ptatFactoryOffset,
   output logic convStart,
   output logic [4:0] convChannel,
   output logic convAbort,
   output logic convRatiometric,
   output logic [2:0] cellSelect,
   output logic cellRouteEnable,
   output logic windowCompSuspend,
   output logic thermRefEnable,
   output logic ptatInputEnable
);
   // Control registers
   logic [2:0] cellSel_r, cellSel_nxt;
   logic selEn_r, selEn_nxt;
   logic [5:0] mode_r, mode_nxt;
   logic [6:0] en1_r, en1_nxt;
   logic [7:0] en2_r, en2_nxt;
   logic [4:0] en3_r, en3_nxt;
   logic thermRef_r, thermRef_nxt;
   logic ptatEn_r, ptatEn_nxt;
   logic go_r, go_nxt;
   logic cellRoute_r, cellRoute_nxt;
   logic winSusp_r, winSusp_nxt;
   logic ready_r, ready_nxt;
   logic [7:0] ptatOff_r;
   // Readout lock state
   logic hRead_r, hRead_nxt;
   logic [5:0] prevGroup_r, prevGroup_nxt;
   logic [23:0] snapWord_r, snapWord_nxt;
   logic [5:0] snapGroup_r, snapGroup_nxt;
   logic snapValid_r, snapValid_nxt;
   // Interconnect
   logic [20:0] enMask;
   logic running, finish, wrEn;
   logic [4:0] wrChan;
   logic [23:0] wrData;
   logic [23:0] memWord;
   logic isResult, isHigh, bypassEn;
   logic [4:0] rdChan;
   logic [2:0] rdByte;
   logic [5:0] group;
   logic [7:0] bypassByte, ctrlByte;

   // Channel enables in round-robin order; the cell slot follows the routing
   assign enMask = {en3_r, en2_r[7:3], en1_r[5:0], en2_r[2:0], en1_r[`AAC_EN1_STACK_BIT], cellRoute_r};

   // Register writes, go pulse and results-ready flag
   always_comb
   begin
      cellSel_nxt = cellSel_r;
      selEn_nxt = selEn_r;
      mode_nxt = mode_r;
      en1_nxt = en1_r;
      en2_nxt = en2_r;
      en3_nxt = en3_r;
      thermRef_nxt = thermRef_r;
      ptatEn_nxt = ptatEn_r;
      go_nxt = 1'b0;
      if (regWrite)
         unique case (regAddr)
            `AAC_ADDR_DIAG2:
            begin
               // A direct change between cells is taken as written; the host clears first
               cellSel_nxt = regWrData[`AAC_DIAG2_SEL_MSB:0];
               selEn_nxt = regWrData[`AAC_DIAG2_SELEN_BIT];
            end
            `AAC_ADDR_MODE: mode_nxt = regWrData[5:0];
            `AAC_ADDR_EN1: en1_nxt = regWrData[6:0];
            `AAC_ADDR_EN2: en2_nxt = regWrData;
            `AAC_ADDR_EN3: en3_nxt = regWrData[4:0];
            `AAC_ADDR_CTRL:
            begin
               go_nxt = regWrData[`AAC_CTRL_GO_BIT];
               thermRef_nxt = regWrData[`AAC_CTRL_TREF_BIT];
               ptatEn_nxt = regWrData[`AAC_CTRL_PTAT_BIT];
            end
            default: ;
         endcase
      cellRoute_nxt = selEn_nxt && (cellSel_nxt != 3'h0);
      winSusp_nxt = cellSel_nxt != 3'h0;
      // Finish sets ready and wins over the clear from a new trigger
      ready_nxt = finish ? 1'b1 : (go_r ? 1'b0 : ready_r);
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         cellSel_r <= 3'h0;
         selEn_r <= 1'b0;
         mode_r <= 6'h00;
         en1_r <= 7'h00;
         en2_r <= 8'h00;
         en3_r <= 5'h00;
         thermRef_r <= 1'b0;
         ptatEn_r <= 1'b0;
         go_r <= 1'b0;
         cellRoute_r <= 1'b0;
         winSusp_r <= 1'b0;
         ready_r <= 1'b0;
         ptatOff_r <= 8'h00;
      end
      else
      begin
         cellSel_r <= cellSel_nxt;
         selEn_r <= selEn_nxt;
         mode_r <= mode_nxt;
         en1_r <= en1_nxt;
         en2_r <= en2_nxt;
         en3_r <= en3_nxt;
         thermRef_r <= thermRef_nxt;
         ptatEn_r <= ptatEn_nxt;
         go_r <= go_nxt;
         cellRoute_r <= cellRoute_nxt;
         winSusp_r <= winSusp_nxt;
         ready_r <= ready_nxt;
         // Trim value is sampled by the clock every cycle; the reset clears it to zero
         ptatOff_r <= ptatFactoryOffset;
      end
   end

   // Read decode: control bytes, diagnostic code, frozen low bytes, live results
   always_comb
   begin
      isResult = regAddr < `AAC_RES_END;
      rdChan = regAddr[7:3];
      rdByte = regAddr[2:0];
      isHigh = (rdByte == `AAC_B_CORR_H) || (rdByte == `AAC_B_UNC_H);
      group = {rdChan, rdByte >= `AAC_B_UNC_H};
      unique case (regAddr)
         `AAC_ADDR_DIAG2: ctrlByte = {4'h0, selEn_r, cellSel_r};
         `AAC_ADDR_MODE: ctrlByte = {2'h0, mode_r};
         `AAC_ADDR_EN1: ctrlByte = {1'b0, en1_r};
         `AAC_ADDR_EN2: ctrlByte = en2_r;
         `AAC_ADDR_EN3: ctrlByte = {3'h0, en3_r};
         `AAC_ADDR_CTRL: ctrlByte = {5'h00, ptatEn_r, thermRef_r, 1'b0};
         `AAC_ADDR_STAT: ctrlByte = {6'h00, ready_r, running};
         `AAC_ADDR_PTAT: ctrlByte = ptatOff_r;
         default: ctrlByte = 8'h00;
      endcase
      bypassEn = 1'b1;
      bypassByte = ctrlByte;
      if (isResult)
      begin
         if (running)
            bypassByte = aac_sel_byte(`AAC_DIAG_WORD, rdChan, rdByte);
         else if (!isHigh && hRead_r && (group == prevGroup_r))
            bypassByte = aac_sel_byte(memWord, rdChan, rdByte);
         else if (!isHigh && snapValid_r && (group == snapGroup_r))
            bypassByte = aac_sel_byte(snapWord_r, rdChan, rdByte);
         else
            bypassEn = 1'b0;
      end
      // The word behind a high-byte read is held so its lower bytes stay from one conversion
      hRead_nxt = regRead && isResult && isHigh && !running;
      prevGroup_nxt = group;
      snapWord_nxt = hRead_r ? memWord : snapWord_r;
      snapGroup_nxt = hRead_r ? prevGroup_r : snapGroup_r;
      snapValid_nxt = (hRead_r || snapValid_r) && !go_r;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         hRead_r <= 1'b0;
         prevGroup_r <= 6'h00;
         snapWord_r <= 24'h00_0000;
         snapGroup_r <= 6'h00;
         snapValid_r <= 1'b0;
      end
      else
      begin
         hRead_r <= hRead_nxt;
         prevGroup_r <= prevGroup_nxt;
         snapWord_r <= snapWord_nxt;
         snapGroup_r <= snapGroup_nxt;
         snapValid_r <= snapValid_nxt;
      end
   end

   // Converter codes are stored as delivered: weights, half-reference DAC taps and
   // range judgement all stay with the analog path and the host
   aac_sequencer u_seq (
      .clk(clk),
      .reset(reset),
      .go(go_r),
      .enMask(enMask),
      .gpioMode(mode_r),
      .convDone(convDone),
      .convData(convData),
      .convStart_r(convStart),
      .convChan_r(convChannel),
      .convAbort_r(convAbort),
      .convRatio_r(convRatiometric),
      .wrEn_r(wrEn),
      .wrChan_r(wrChan),
      .wrData_r(wrData),
      .running_r(running),
      .finish_r(finish)
   );

   // One 24-bit word per channel feeds both corrected and uncorrected bytes
   aac_result_mem u_mem (
      .clk(clk),
      .reset(reset),
      .wrEn(wrEn),
      .wrChan(wrChan),
      .wrData(wrData),
      .rdEn(regRead && isResult),
      .rdChan(rdChan),
      .rdByte(rdByte),
      .bypassEn(regRead && bypassEn),
      .bypassByte(bypassByte),
      .rdData_r(regRdData),
      .rdWord_r(memWord)
   );

   assign cellSelect = cellSel_r;
   assign cellRouteEnable = cellRoute_r;
   assign windowCompSuspend = winSusp_r;
   assign thermRefEnable = thermRef_r;
   assign ptatInputEnable = ptatEn_r;

   a_route_follows: assert property (@(posedge clk) disable iff (reset)
      (regWrite && regAddr == `AAC_ADDR_DIAG2) |=>
         cellRouteEnable == ($past(regWrData[`AAC_DIAG2_SELEN_BIT]) &&
            $past(regWrData[`AAC_DIAG2_SEL_MSB:0]) != 3'h0))
      else $error("cell routing does not follow the select write");
   a_window_suspend: assert property (@(posedge clk) disable iff (reset)
      (regWrite && regAddr == `AAC_ADDR_DIAG2) |=>
         windowCompSuspend == ($past(regWrData[`AAC_DIAG2_SEL_MSB:0]) != 3'h0))
      else $error("window comparator suspend does not match cell select");
   a_diag_code: assert property (@(posedge clk) disable iff (reset)
      (regRead && running && regAddr < `AAC_RES_END && regAddr[2:0] == 3'h0) |=> regRdData == 8'h80)
      else $error("early result read did not return the diagnostic code");
   a_ready_late: assert property (@(posedge clk) disable iff (reset)
      $rose(ready_r) |-> $past(finish) && !running && !$past(wrEn))
      else $error("results ready raised before all writes");
   a_go_aborts: assert property (@(posedge clk) disable iff (reset)
      (go_r && running) |=> convAbort && running && convChannel == `AAC_CH_CELL ##1 (convChannel <= `AAC_CH_BAT))
      else $error("trigger during a round did not restart it");
   a_stack_gate: assert property (@(posedge clk) disable iff (reset)
      (convStart && convChannel == `AAC_CH_BAT) |-> $past(en1_r[`AAC_EN1_STACK_BIT]))
      else $error("stack voltage converted while disabled");
   a_gpio_mode: assert property (@(posedge clk) disable iff (reset)
      (convStart && convChannel == `AAC_CH_GPIO1) |-> convRatiometric == $past(mode_r[0]))
      else $error("first input converted in the wrong mode");
   a_lock_hold: assert property (@(posedge clk) disable iff (reset)
      (hRead_r && regRead && !isHigh && group == prevGroup_r && !running)
         |=> regRdData == aac_sel_byte($past(memWord), $past(rdChan), $past(rdByte)))
      else $error("low byte after high read came from another conversion");
endmodule

// [verification/aac_conv_model.sv]
module aac_conv_model
(
   input wire logic clk,
   input wire logic reset,
   input wire logic convStart,
   input wire logic [4:0] convChannel,
   input wire logic convAbort,
   input wire logic slow,
   input wire logic [7:0] salt,
   output logic convDone,
   output logic [23:0] convData
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned waitLeft;
   logic [4:0] chan;

   // Converter answers a start after a short or long settle; an abort drops the pending result
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         waitLeft <= 0;
         convDone <= 1'b0;
         convData <= 24'h00_0000;
      end
      else
      begin
         convDone <= 1'b0;
         convData <= ~convData; // Outside a result the bus toggles, so stale data never matches
         if (convAbort)
            waitLeft <= 0;
         else if (convStart)
         begin
            chan <= convChannel;
            waitLeft <= slow ? 20 : 2;
         end
         else if (waitLeft == 1)
         begin
            waitLeft <= 0;
            convDone <= 1'b1;
            convData <= {~{3'h0, chan}, salt, 3'h0, chan}; // Negative codes on purpose
         end
         else if (waitLeft != 0)
            waitLeft <= waitLeft - 1;
      end
   end
endmodule

// [verification/tb.sv]
`include "aac_cfg.svh"

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, reset = 1'b1, regWrite = 1'b0, regRead = 1'b0, slow = 1'b0;
   logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, salt = 8'hA5;
   logic convDone, convStart, convAbort, convRatiometric, cellRouteEnable;
   logic windowCompSuspend, thermRefEnable, ptatInputEnable, abortSeen;
   logic [23:0] convData;
   logic [4:0] convChannel;
   logic [2:0] cellSelect;
   logic [5:0] startLog[$];
   int bad_count = 0;
   int comparisons = 0;

   always #2.5 clk = ~clk;

   aac_result_readout aac_result_readout_i (.clk(clk), .reset(reset), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .convDone(convDone), .convData(convData), .ptatFactoryOffset(8'hF3), .convStart(convStart),
      .convChannel(convChannel), .convAbort(convAbort), .convRatiometric(convRatiometric),
      .cellSelect(cellSelect), .cellRouteEnable(cellRouteEnable), .windowCompSuspend(windowCompSuspend),
      .thermRefEnable(thermRefEnable), .ptatInputEnable(ptatInputEnable));

   aac_conv_model aac_conv_model_i (.clk(clk), .reset(reset), .convStart(convStart),
      .convChannel(convChannel), .convAbort(convAbort), .slow(slow), .salt(salt),
      .convDone(convDone), .convData(convData));

   // Log of started channels; mode bit kept only for the analog inputs
   always @(posedge clk)
   begin
      if (convAbort === 1'b1)
      begin
         abortSeen = 1'b1;
         startLog.delete();
      end
      if (convStart === 1'b1)
         startLog.push_back({convRatiometric && convChannel >= 5'h05 && convChannel <= 5'h0A, convChannel});
   end

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'b0;
      #1 d = regRdData;
   endtask

   task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk(what, exp, d);
   endtask

   // High and low byte on back-to-back strobes, so the low byte is served from the lock
   task automatic rdp(input string what, input logic [7:0] a, input logic [7:0] expH, input logic [7:0] expL);
      logic [7:0] h;
      logic [7:0] l;
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regAddr <= a + 8'h01;
      #1 h = regRdData;
      @(posedge clk);
      regRead <= 1'b0;
      #1 l = regRdData;
      chk(what, expH, h);
      chk(what, expL, l);
   endtask

   // Pin outputs after a write has landed
   task automatic outs(input logic [7:0] exp);
      repeat (2) @(posedge clk);
      #1 chk("pins", exp, {1'b0, cellSelect, cellRouteEnable, windowCompSuspend, thermRefEnable, ptatInputEnable});
   endtask

   // Whole result group, high byte first so the lower bytes come from one conversion
   task automatic grp(input logic [4:0] ch);
      logic [23:0] w;
      logic [7:0] a;
      w = {~{3'h0, ch}, salt, 3'h0, ch};
      a = {ch, 3'h0};
      rdc("corr high", a, w[23:16]);
      rdc("corr low", a + 8'h01, w[15:8]);
      if (ch == 5'h01 || ch == 5'h05)
      begin
         rdc("unc high", a + 8'h02, w[23:16]);
         rdc("unc mid", a + 8'h03, w[15:8]);
         rdc("unc low", a + 8'h04, w[7:0]);
      end
      else if (ch >= 5'h06 && ch <= 5'h0A)
      begin
         rdc("unc high", a + 8'h02, w[23:16]);
         rdc("unc low", a + 8'h04, w[15:8]);
      end
   endtask

   // One round; with twice set a second trigger lands while the first channel converts
   task automatic go_wait(input logic twice, input logic [5:0] exp[$]);
      logic [7:0] d;
      abortSeen = 1'b0;
      startLog.delete();
      wr(`AAC_ADDR_CTRL, 8'h03); // Reference kept on for the inputs
      if (twice)
      begin
         for (int i = 0; i < 50 && startLog.size() == 0; i++)
            @(posedge clk);
         wr(`AAC_ADDR_CTRL, 8'h03);
      end
      repeat (2) @(posedge clk);
      rdc("status busy", `AAC_ADDR_STAT, 8'h01);
      rdc("early result", 8'h28, 8'h80);
      d = 8'h00;
      for (int i = 0; i < 400 && d[1] !== 1'b1; i++)
         rd(`AAC_ADDR_STAT, d);
      chk("status done", 8'h02, d);
      chk("abort", {7'h00, twice}, {7'h00, abortSeen});
      chk("starts", 8'(exp.size()), 8'(startLog.size()));
      foreach (exp[i])
         chk("started", {2'h0, exp[i]}, {2'h0, startLog[i]});
   endtask

   task automatic t_reset();
      rdc("status", `AAC_ADDR_STAT, 8'h00);
      rdc("unmapped", 8'hF0, 8'h00);
      rdc("unconverted", 8'h08, 8'h80);
      rdc("ptat offset", `AAC_ADDR_PTAT, 8'hF3);
   endtask

   task automatic t_controls();
      wr(`AAC_ADDR_DIAG2, 8'h0B);
      outs(8'h3C);
      rdc("diag2", `AAC_ADDR_DIAG2, 8'h0B);
      wr(`AAC_ADDR_DIAG2, 8'h00); // Cleared before a new cell
      outs(8'h00);
      wr(`AAC_ADDR_DIAG2, 8'h05);
      outs(8'h54);
      wr(`AAC_ADDR_DIAG2, 8'h00);
      wr(`AAC_ADDR_CTRL, 8'h06);
      outs(8'h03);
      rdc("ctrl", `AAC_ADDR_CTRL, 8'h06);
      wr(`AAC_ADDR_CTRL, 8'h02);
      outs(8'h02);
      wr(`AAC_ADDR_PTAT, 8'h00);
      rdc("ptat read only", `AAC_ADDR_PTAT, 8'hF3);
      wr(`AAC_ADDR_MODE, 8'h15);
      rdc("mode", `AAC_ADDR_MODE, 8'h15);
   endtask

   task automatic t_round();
      wr(`AAC_ADDR_DIAG2, 8'h09); // Cell in the round refreshes die temperature
      wr(`AAC_ADDR_MODE, 8'h01);
      wr(`AAC_ADDR_EN1, 8'h43);
      wr(`AAC_ADDR_EN2, 8'h10);
      wr(`AAC_ADDR_EN3, 8'h08);
      go_wait(1'b0, '{6'h00, 6'h01, 6'h25, 6'h06, 6'h0C, 6'h13});
      grp(5'h00);
      grp(5'h01);
      grp(5'h05);
      grp(5'h06);
      grp(5'h0C);
      grp(5'h13);
      rdc("skipped", 8'h10, 8'h80);
   endtask

   task automatic t_abort();
      salt = 8'h5A;
      slow = 1'b1;
      wr(`AAC_ADDR_EN1, 8'h03);
      go_wait(1'b1, '{6'h00, 6'h25, 6'h06, 6'h0C, 6'h13});
      grp(5'h00);
      grp(5'h05);
      grp(5'h06);
      rdp("gpio1 pair", 8'h28, 8'hFA, 8'h5A);
   endtask

   initial
   begin
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_controls();
      t_round();
      t_abort();
      give_verdict();
   end

   // Whole run needs a few hundred cycles; this cuts a hang short
   initial
   begin
      #250us;
      bad_count++;
      $display("[ERR] watchdog expected done seen hang");
      give_verdict();
   end
endmodule
